// ==== common/adc_comb_defines.vh ====
`ifndef ADC_COMB_DEFINES_VH
`define ADC_COMB_DEFINES_VH

// register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_GAIN 8'h04
`define OFS_TIMER0 8'h08
`define OFS_TIMER1 8'h0C
`define OFS_TIMER2 8'h10
`define OFS_TIMER3 8'h14
`define OFS_COMB0 8'h18
`define OFS_COMB1 8'h1C
`define OFS_STATUS 8'h20
`define OFS_MASK 8'h24
`define OFS_RESULT 8'h28

// control register fields
`define CTRL_EN_LSB 0
`define CTRL_TRIG_LSB 4
`define CTRL_FMODE_LSB 8
`define CTRL_XGAIN_LSB 10
`define CTRL_DIFF_LSB 14
`define CTRL_SRC0_LSB 18
`define CTRL_SRC1_LSB 20

// filter routing modes
`define FMODE_BYPASS 2'h0
`define FMODE_SINGLE 2'h1
`define FMODE_PARALLEL 2'h2
`define FMODE_CASCADE 2'h3

// comb register fields: order minus one, decimation minus one
`define COMB_ORDER_LSB 0
`define COMB_DECIM_LSB 8

// status and mask bits
`define ST_NEW_RESULT 0
`define ST_OVERRUN 1

// reset values
`define RST_CTRL 32'h0000_0000
`define RST_GAIN 8'h00
`define RST_TIMER 16'hFFFF
`define RST_COMB 5'h00

`endif

// ==== core/comb_stage.v ====
`timescale 1ns/1ps
// recursive moving-sum filter with decimation
module comb_stage #(
   parameter IN_W = 10,
   parameter LOG_N = 5
) (
   input wire mclk,
   input wire nrst,
   input wire clr,
   input wire [LOG_N-1:0] order_m1,
   input wire [LOG_N-1:0] decim_m1,
   input wire in_valid,
   input wire [IN_W-1:0] in_data,
   output reg out_valid,
   output reg [IN_W+LOG_N-1:0] out_data
);
   localparam MAX_N = 1 << LOG_N;
   localparam ACC_W = IN_W + LOG_N;

   reg [IN_W-1:0] hist [0:MAX_N-1];
   reg [LOG_N-1:0] wp_q;
   reg [LOG_N:0] fill_q;
   reg [ACC_W-1:0] acc_q;
   reg [LOG_N-1:0] dcnt_q;
   wire [LOG_N:0] order_n;
   wire [LOG_N-1:0] old_idx;
   wire [ACC_W-1:0] drop;
   wire [ACC_W-1:0] acc_d;

   assign order_n = {1'b0, order_m1} + {{LOG_N{1'b0}}, 1'b1};
   assign old_idx = wp_q - order_n[LOG_N-1:0];
   // drop the sample that leaves the window once the window is full
   assign drop = (fill_q >= order_n) ? {{LOG_N{1'b0}}, hist[old_idx]} : {ACC_W{1'b0}};
   // one add and one subtract per sample at any order
   assign acc_d = acc_q + {{LOG_N{1'b0}}, in_data} - drop;

   ////////////////////////////////////////////////////////////////////////////
   // sample history, no reset needed: fill count masks stale words
   always @(posedge mclk) begin
      if (in_valid) begin
         hist[wp_q] <= in_data;
      end
   end

   // accumulator, fill count and decimation counter
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wp_q <= {LOG_N{1'b0}};
         fill_q <= {(LOG_N+1){1'b0}};
         acc_q <= {ACC_W{1'b0}};
         dcnt_q <= {LOG_N{1'b0}};
         out_valid <= 1'b0;
         out_data <= {ACC_W{1'b0}};
      end else if (clr) begin
         wp_q <= {LOG_N{1'b0}};
         fill_q <= {(LOG_N+1){1'b0}};
         acc_q <= {ACC_W{1'b0}};
         dcnt_q <= {LOG_N{1'b0}};
         out_valid <= 1'b0;
      end else begin
         out_valid <= 1'b0;
         if (in_valid) begin
            wp_q <= wp_q + {{(LOG_N-1){1'b0}}, 1'b1};
            if (fill_q != {1'b1, {LOG_N{1'b0}}}) begin
               fill_q <= fill_q + {{LOG_N{1'b0}}, 1'b1};
            end
            acc_q <= acc_d;
            // emit every decim-th sum
            if (dcnt_q == decim_m1) begin
               dcnt_q <= {LOG_N{1'b0}};
               out_valid <= 1'b1;
               out_data <= acc_d;
            end else begin
               dcnt_q <= dcnt_q + {{(LOG_N-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // comb_stage

// ==== core/adc_comb_path.v ====
`timescale 1ns/1ps
`include "adc_comb_defines.vh"
// Summary of operation
// - each comb output is the plain sum of the last N samples, unit weights
// - combs are recursive: one add and one subtract per sample at any order
// - two combs, each with its own order and decimation setting
// - cascade mode feeds comb 0 output into comb 1; comb 1 gives result
// - bypass mode passes each raw result unchanged to the DMA request path
// - parallel mode routes two channels each through its own comb
// - four input channels, each selectable differential
// - gain 1, 2, 4 or 8 per channel, applied when that channel converts
// - per channel start mode: free-running timer or trigger event
// - each channel timer has its own period; expiry requests that channel only
// - external trigger and gain-control inputs accepted
// - a request selects its channel and its result path automatically
// - a final result raises a new-result event that starts the DMA transfer
module adc_comb_path #(
   parameter SMP_W = 10,
   parameter LOG_N = 5,
   parameter TMR_W = 16
) (
   input wire mclk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [3:0] ext_trig,
   input wire [7:0] ext_gain,
   output reg conv_start,
   output reg [1:0] conv_channel,
   output reg [1:0] conv_gain,
   output reg conv_diff,
   input wire conv_done,
   input wire [SMP_W-1:0] conv_data,
   output reg result_new,
   output reg [SMP_W+2*LOG_N-1:0] result_data,
   output reg [1:0] result_channel,
   output wire irq
);
   localparam ACC0_W = SMP_W + LOG_N;
   localparam RES_W = SMP_W + 2 * LOG_N;

   reg [31:0] ctrl_q;
   reg [7:0] gain_q;
   reg [TMR_W-1:0] period_q [0:3];
   reg [LOG_N-1:0] order0_q, decim0_q, order1_q, decim1_q;
   reg [1:0] status_q;
   reg [1:0] mask_q;
   reg clr_q;
   reg [3:0] trig_s1_q, trig_s2_q, trig_s3_q;
   reg [7:0] gain_s1_q, gain_s2_q;
   reg [TMR_W-1:0] tmr_q [0:3];
   reg [3:0] pend_q;
   reg busy_q;
   reg [1:0] cur_q;
   reg overrun_q;
   reg [3:0] req;
   reg [1:0] grant_ch;
   reg grant;
   integer i;
   integer j;
   integer k;
   integer m;

   wire [1:0] fmode;
   wire [1:0] src0, src1;
   wire c0_in_v, c1_in_v, c0_out_v, c1_out_v;
   wire [ACC0_W-1:0] c0_out;
   wire [ACC0_W-1:0] c1_in;
   wire [RES_W-1:0] c1_out;
   wire raw_v;
   wire to0, to1;

   // two-bit field of a packed per-channel vector
   function [1:0] pick2;
      input [7:0] vec;
      input [1:0] ch;
      begin
         pick2 = vec[2*ch +: 2];
      end
   endfunction

   // timer index for a timer register address, valid when in range
   function [1:0] tmr_index;
      input [7:0] a;
      begin
         tmr_index = a[3:2] - 2'h2;
      end
   endfunction

   function is_tmr;
      input [7:0] a;
      begin
         is_tmr = (a >= `OFS_TIMER0) && (a <= `OFS_TIMER3);
      end
   endfunction

   assign fmode = ctrl_q[`CTRL_FMODE_LSB +: 2];
   assign src0 = ctrl_q[`CTRL_SRC0_LSB +: 2];
   assign src1 = ctrl_q[`CTRL_SRC1_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // register writes; order/decim/mode changes restart both filters
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `RST_CTRL;
         gain_q <= `RST_GAIN;
         for (i = 0; i < 4; i = i + 1) begin
            period_q[i] <= `RST_TIMER;
         end
         order0_q <= `RST_COMB;
         decim0_q <= `RST_COMB;
         order1_q <= `RST_COMB;
         decim1_q <= `RST_COMB;
         mask_q <= 2'h0;
         clr_q <= 1'b0;
      end else begin
         clr_q <= 1'b0;
         if (reg_wr) begin
            if (reg_addr == `OFS_CTRL) begin
               ctrl_q <= reg_wdata;
               clr_q <= 1'b1;
            end
            if (reg_addr == `OFS_GAIN) begin
               gain_q <= reg_wdata[7:0];
            end
            if (is_tmr(reg_addr)) begin
               period_q[tmr_index(reg_addr)] <= reg_wdata[TMR_W-1:0];
            end
            if (reg_addr == `OFS_COMB0) begin
               order0_q <= reg_wdata[`COMB_ORDER_LSB +: LOG_N];
               decim0_q <= reg_wdata[`COMB_DECIM_LSB +: LOG_N];
               clr_q <= 1'b1;
            end
            if (reg_addr == `OFS_COMB1) begin
               order1_q <= reg_wdata[`COMB_ORDER_LSB +: LOG_N];
               decim1_q <= reg_wdata[`COMB_DECIM_LSB +: LOG_N];
               clr_q <= 1'b1;
            end
            if (reg_addr == `OFS_MASK) begin
               mask_q <= reg_wdata[1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data one cycle after the strobe; unmapped reads return zero
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_CTRL: reg_rdata <= ctrl_q;
            `OFS_GAIN: reg_rdata <= {24'h00_0000, gain_q};
            `OFS_TIMER0, `OFS_TIMER1, `OFS_TIMER2, `OFS_TIMER3:
               reg_rdata <= {{(32-TMR_W){1'b0}}, period_q[tmr_index(reg_addr)]};
            `OFS_COMB0: reg_rdata <= {{(24-LOG_N){1'b0}}, decim0_q, 3'h0, order0_q};
            `OFS_COMB1: reg_rdata <= {{(24-LOG_N){1'b0}}, decim1_q, 3'h0, order1_q};
            `OFS_STATUS: reg_rdata <= {30'h0000_0000, status_q};
            `OFS_MASK: reg_rdata <= {30'h0000_0000, mask_q};
            `OFS_RESULT: reg_rdata <= {{(30-RES_W){1'b0}}, result_channel, result_data};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status, cleared by reading it; a same-cycle event wins
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         status_q <= 2'h0;
      end else begin
         status_q[`ST_NEW_RESULT] <= (status_q[`ST_NEW_RESULT] & ~(reg_rd && reg_addr == `OFS_STATUS))
            | result_new;
         status_q[`ST_OVERRUN] <= (status_q[`ST_OVERRUN] & ~(reg_rd && reg_addr == `OFS_STATUS))
            | overrun_q;
      end
   end

   assign irq = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for external trigger and gain pins
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trig_s1_q <= 4'h0;
         trig_s2_q <= 4'h0;
         trig_s3_q <= 4'h0;
         gain_s1_q <= 8'h00;
         gain_s2_q <= 8'h00;
      end else begin
         trig_s1_q <= ext_trig;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
         gain_s1_q <= ext_gain;
         gain_s2_q <= gain_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel timers and request sources
   always @* begin
      for (j = 0; j < 4; j = j + 1) begin
         if (!ctrl_q[`CTRL_EN_LSB + j]) begin
            req[j] = 1'b0;
         end else if (ctrl_q[`CTRL_TRIG_LSB + j]) begin
            req[j] = trig_s2_q[j] & ~trig_s3_q[j];
         end else begin
            req[j] = (tmr_q[j] == period_q[j]);
         end
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (m = 0; m < 4; m = m + 1) begin
            tmr_q[m] <= {TMR_W{1'b0}};
         end
      end else begin
         for (m = 0; m < 4; m = m + 1) begin
            if (!ctrl_q[`CTRL_EN_LSB + m] || ctrl_q[`CTRL_TRIG_LSB + m] || tmr_q[m] == period_q[m]) begin
               tmr_q[m] <= {TMR_W{1'b0}};
            end else begin
               tmr_q[m] <= tmr_q[m] + {{(TMR_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lowest pending channel wins the converter when it is idle
   always @* begin
      grant = 1'b0;
      grant_ch = 2'h0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (pend_q[k] && !busy_q) begin
            grant = 1'b1;
            grant_ch = k[1:0];
         end
      end
   end

   // pending requests, conversion start with channel gain and input type
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pend_q <= 4'h0;
         busy_q <= 1'b0;
         cur_q <= 2'h0;
         overrun_q <= 1'b0;
         conv_start <= 1'b0;
         conv_channel <= 2'h0;
         conv_gain <= 2'h0;
         conv_diff <= 1'b0;
      end else begin
         // a request arriving while its channel waits counts as overrun
         overrun_q <= |(req & pend_q & ~(grant ? (4'h1 << grant_ch) : 4'h0));
         pend_q <= (pend_q & ~(grant ? (4'h1 << grant_ch) : 4'h0)) | req;
         conv_start <= grant;
         if (grant) begin
            busy_q <= 1'b1;
            cur_q <= grant_ch;
            conv_channel <= grant_ch;
            conv_diff <= ctrl_q[`CTRL_DIFF_LSB + grant_ch];
            conv_gain <= ctrl_q[`CTRL_XGAIN_LSB + grant_ch] ? pick2(gain_s2_q, grant_ch)
               : pick2(gain_q, grant_ch);
         end else if (conv_done) begin
            busy_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result routing by filter mode and converted channel
   assign to0 = (fmode != `FMODE_BYPASS) && (cur_q == src0);
   assign to1 = (fmode == `FMODE_PARALLEL) && (cur_q == src1) && !to0;
   assign c0_in_v = busy_q && conv_done && to0;
   assign c1_in_v = (fmode == `FMODE_CASCADE) ? c0_out_v : (busy_q && conv_done && to1);
   assign c1_in = (fmode == `FMODE_CASCADE) ? c0_out : {{LOG_N{1'b0}}, conv_data};
   assign raw_v = busy_q && conv_done && !to0 && !to1;

   comb_stage #(.IN_W(SMP_W), .LOG_N(LOG_N)) u_comb0 (
      .mclk(mclk),
      .nrst(nrst),
      .clr(clr_q),
      .order_m1(order0_q),
      .decim_m1(decim0_q),
      .in_valid(c0_in_v),
      .in_data(conv_data),
      .out_valid(c0_out_v),
      .out_data(c0_out)
   );

   comb_stage #(.IN_W(ACC0_W), .LOG_N(LOG_N)) u_comb1 (
      .mclk(mclk),
      .nrst(nrst),
      .clr(clr_q),
      .order_m1(order1_q),
      .decim_m1(decim1_q),
      .in_valid(c1_in_v),
      .in_data(c1_in),
      .out_valid(c1_out_v),
      .out_data(c1_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // final result register and new-result event toward the DMA engine
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         result_new <= 1'b0;
         result_data <= {RES_W{1'b0}};
         result_channel <= 2'h0;
      end else begin
         result_new <= 1'b0;
         if (c1_out_v) begin
            result_new <= 1'b1;
            result_data <= c1_out;
            result_channel <= (fmode == `FMODE_CASCADE) ? src0 : src1;
         end else if (c0_out_v && fmode != `FMODE_CASCADE) begin
            result_new <= 1'b1;
            result_data <= {{LOG_N{1'b0}}, c0_out};
            result_channel <= src0;
         end else if (raw_v) begin
            result_new <= 1'b1;
            result_data <= {{(2*LOG_N){1'b0}}, conv_data};
            result_channel <= cur_q;
         end
      end
   end
endmodule // adc_comb_path

// ==== testbench/conv_model.sv ====
`timescale 1ns/1ps
// converter model: one sample per start, lat+1 cycles after it or later while stalled
module conv_model (
   input wire mclk,
   input wire nrst,
   input wire conv_start,
   input wire [3:0] lat,
   input wire stall,
   input wire full,
   output reg conv_done,
   output reg [9:0] conv_data
);
   int cnt;
   // count down the conversion; the idle bus toggles so stale data never looks valid
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         conv_done <= 1'b0;
         conv_data <= 10'h155;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start) cnt <= lat;
         else if (cnt > 1) cnt <= cnt - 1;
         else if (cnt == 1 && !stall) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_data <= full ? 10'h3FF : 10'($urandom);
         end
      end
   end
endmodule // conv_model

// ==== testbench/adc_comb_path_sva.sv ====
`timescale 1ns/1ps
`include "adc_comb_defines.vh"
module adc_comb_path_sva #(
   parameter SMP_W = 10,
   parameter LOG_N = 5
) (
   input wire mclk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire conv_start,
   input wire [1:0] conv_channel,
   input wire [1:0] conv_gain,
   input wire conv_diff,
   input wire conv_done,
   input wire [SMP_W-1:0] conv_data,
   input wire result_new,
   input wire [SMP_W+2*LOG_N-1:0] result_data,
   input wire [1:0] result_channel,
   input wire irq
);
   reg [31:0] ctrl_q;
   reg [7:0] gain_q;
   reg [1:0] mask_q;
   reg busy_q;
   reg seen_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////
   // shadow of settings, converter busy and first sample seen
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 32'h0;
         gain_q <= 8'h00;
         mask_q <= 2'h0;
         busy_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `OFS_CTRL) ctrl_q <= reg_wdata;
         if (reg_wr && reg_addr == `OFS_GAIN) gain_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == `OFS_MASK) mask_q <= reg_wdata[1:0];
         if (conv_start) busy_q <= 1'b1;
         else if (conv_done) busy_q <= 1'b0;
         if (conv_done) seen_q <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // raw sample in bypass, then the same sample out as the result
   sequence s_raw_in;
      conv_done && ctrl_q[9:8] == `FMODE_BYPASS;
   endsequence
   sequence s_raw_out;
      result_new && result_data == $past(conv_data) && result_channel == $past(conv_channel);
   endsequence
   a_bypass_pass: assert property (s_raw_in |=> s_raw_out)
      else $error("bypass result differs from raw sample");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   a_start_idle: assert property (conv_start |-> !busy_q)
      else $error("start while converter busy");
   a_cfg_holds: assert property (!conv_start |-> $stable(conv_channel) && $stable(conv_gain) && $stable(conv_diff))
      else $error("conversion setup changed without a start");
   a_gain_select: assert property (conv_start && !ctrl_q[10 + conv_channel] |-> conv_gain == gain_q[conv_channel*2 +: 2])
      else $error("gain code differs from channel setting");
   a_diff_select: assert property (conv_start |-> conv_diff == ctrl_q[14 + conv_channel])
      else $error("differential select differs from channel setting");
   a_result_pulse: assert property (result_new |=> !result_new)
      else $error("new result longer than one cycle");
   a_result_stands: assert property (!result_new |-> $stable(result_data) && $stable(result_channel))
      else $error("result changed without new result");
   a_no_early: assert property (result_new |-> seen_q)
      else $error("result before any sample after reset");
   a_irq_masked: assert property (mask_q == 2'h0 |-> !irq)
      else $error("interrupt while all sources masked");
endmodule // adc_comb_path_sva
bind adc_comb_path adc_comb_path_sva #(.SMP_W(SMP_W), .LOG_N(LOG_N)) chk_u (.mclk(mclk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conv_start(conv_start),
   .conv_channel(conv_channel), .conv_gain(conv_gain), .conv_diff(conv_diff), .conv_done(conv_done),
   .conv_data(conv_data), .result_new(result_new), .result_data(result_data),
   .result_channel(result_channel), .irq(irq));

// ==== testbench/test_adc_comb_path.sv ====
`timescale 1ns/1ps
`include "adc_comb_defines.vh"
module test_adc_comb_path;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] ext_trig = 4'h0;
   logic [7:0] ext_gain = 8'h00;
   logic [3:0] lat = 4'h2;
   logic stall = 1'b0;
   logic full = 1'b0;
   wire [31:0] reg_rdata;
   wire conv_start, conv_diff, conv_done, result_new, irq;
   wire [1:0] conv_channel, conv_gain, result_channel;
   wire [9:0] conv_data;
   wire [19:0] result_data;
   int failures = 0;
   int cmp_count = 0;
   int starts = 0;
   int cyc = 0;
   int dma_words = 0;
   int dma_blocks = 0;
   bit cap_en = 0;
   int samp[4][$];
   logic [31:0] res[4][$];
   int e0[$];
   int e1[$];
   logic [31:0] v;
   int g, n, d, t0, t1;
   adc_comb_path dut_u (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig(ext_trig), .ext_gain(ext_gain), .conv_start(conv_start),
      .conv_channel(conv_channel), .conv_gain(conv_gain), .conv_diff(conv_diff), .conv_done(conv_done),
      .conv_data(conv_data), .result_new(result_new), .result_data(result_data),
      .result_channel(result_channel), .irq(irq));
   conv_model conv_u (.mclk(mclk), .nrst(nrst), .conv_start(conv_start), .lat(lat), .stall(stall),
      .full(full), .conv_done(conv_done), .conv_data(conv_data));
   ////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      wrap_up;
   end
   // collect samples and results per channel, as the transfer engine would
   always @(posedge mclk) begin
      cyc++;
      if (conv_done && cap_en) samp[conv_channel].push_back(conv_data);
      // each result is queued for its channel; every 16th result counts one more DMA block
      if (result_new) begin
         res[result_channel].push_back(result_data);
         dma_words++;
         if (dma_words % 16 == 0) dma_blocks++;
      end
      if (conv_start) starts++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         failures++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // moving sum of the last nn inputs, fewer while filling, every dd-th input
   function automatic void comb_ref(input int nn, input int dd, input int q[$], output int o[$]);
      int s;
      o = {};
      for (int k = 0; k < q.size(); k++) begin
         s = 0;
         for (int j = (k >= nn) ? k - nn + 1 : 0; j <= k; j++) s += q[j];
         if ((k + 1) % dd == 0) o.push_back(s);
      end
   endfunction
   task automatic cmp_ch(input int ch, input int n0, input int d0, input int n1, input int d1);
      comb_ref(n0, d0, samp[ch], e0);
      comb_ref(n1, d1, e0, e1);
      chk("results present", 1, e1.size() > 0);
      chk("result count", e1.size(), res[ch].size());
      foreach (e1[i]) if (i < res[ch].size()) chk("result data", e1[i], res[ch][i]);
   endtask
   // configure, run, then stall the converter so nothing more arrives
   task automatic run(input logic [31:0] ctrl, input logic [31:0] c0, input logic [31:0] c1);
      wr(`OFS_COMB0, c0);
      wr(`OFS_COMB1, c1);
      for (int i = 0; i < 4; i++) begin
         samp[i].delete();
         res[i].delete();
      end
      cap_en = 1;
      wr(`OFS_CTRL, ctrl);
      repeat (700) @(posedge mclk);
      stall <= 1'b1;
      repeat (12) @(posedge mclk);
      cap_en = 0;
   endtask
   task automatic drain;
      wr(`OFS_CTRL, 32'h0);
      stall <= 1'b0;
      repeat (40) @(posedge mclk);
   endtask
   task automatic wait_start(output int t);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (conv_start !== 1'b1 && k < 300);
      if (conv_start !== 1'b1) failures++;
      t = cyc;
   endtask
   task automatic wrap_up;
      $display("compares %0d failures %0d blocks %0d", cmp_count, failures, dma_blocks);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'hF2A3793D));
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rd(`OFS_TIMER0);
      chk("timer0 reset", 32'h0000FFFF, v);
      rd(`OFS_STATUS);
      chk("status reset", 32'h0, v);
      rd(8'h3C);
      chk("unmapped read", 32'h0, v);
      for (int i = 0; i < 4; i++) wr(8'(`OFS_TIMER0 + 4 * i), 30 + $urandom_range(10));
      g = $urandom;
      wr(`OFS_GAIN, g[7:0]);
      wr(`OFS_MASK, 32'h1);
      lat <= 4'($urandom_range(3, 1));
      run(32'h0000000F | ($urandom_range(15) << 14), 32'h0, 32'h0);
      for (int c = 0; c < 4; c++) cmp_ch(c, 1, 1, 1, 1);
      chk("irq raised", 1'b1, irq);
      rd(`OFS_STATUS);
      chk("status new result", 1'b1, v[`ST_NEW_RESULT]);
      chk("irq after status read", 1'b0, irq);
      wr(`OFS_MASK, 32'h0);
      drain;
      for (int c = 0; c < 4; c++) begin
         wr(8'(`OFS_TIMER0 + 4 * c), 7 + c);
         wr(`OFS_CTRL, 32'h1 << c);
         wait_start(t0);
         wait_start(t0);
         wait_start(t1);
         chk("timer interval", 8 + c, t1 - t0);
         chk("start channel", c, conv_channel);
         drain;
      end
      for (int r = 0; r < 3; r++) begin
         n = (r == 1) ? 32 : $urandom_range(8, 2);
         d = (r == 1) ? 1 : $urandom_range(4, 1);
         full <= (r == 1);
         run(32'h00000103, 32'((n - 1) | ((d - 1) << 8)), 32'h0);
         cmp_ch(0, n, d, 1, 1);
         cmp_ch(1, 1, 1, 1, 1);
         drain;
      end
      full <= 1'b0;
      n = $urandom_range(6, 2);
      d = $urandom_range(3, 1);
      run(32'h00200205, 32'((n - 1) | ((d - 1) << 8)), 32'h00000201);
      cmp_ch(0, n, d, 1, 1);
      cmp_ch(2, 2, 3, 1, 1);
      drain;
      run(32'h00040302, 32'((n - 1) | ((d - 1) << 8)), 32'h00000102);
      cmp_ch(1, n, d, 3, 2);
      drain;
      g = $urandom_range(3);
      ext_gain <= 8'(g << 6);
      wr(`OFS_CTRL, 32'h00002088);
      repeat (20) @(posedge mclk);
      ext_trig <= 4'h8;
      #1;
      n = starts;
      wait_start(t0);
      chk("trigger channel", 3, conv_channel);
      chk("pin gain", g, conv_gain);
      @(posedge mclk);
      ext_trig <= 4'h0;
      repeat (60) @(posedge mclk);
      chk("starts per trigger", 1, starts - n);
      drain;
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rd(`OFS_TIMER1);
      chk("timer1 after reset", 32'h0000FFFF, v);
      wrap_up;
   end
endmodule // test_adc_comb_path
